/* File: cis_core_interrupt_sequencer.sv */
// Purpose: interrupt and reset sequencing of an 8-bit core
// Assumes: requests come from logic on sys_clk; pipeline flags a boundary
// Notes:   source 0 is the highest priority after reset
// Function
// - each source has its own low vector
// - lower vector address wins arbitration
// - serve only when individual and global enabled
// - select bit and fuse relocate vectors
// - lock bits may suppress by program counter
// - entry clears global enable
// - software set enable allows nesting
// - entry clears the served flag
// - writing one clears a flag
// - disabled flag requests stay latched
// - level requests only while present
// - one instruction runs after return
// - status register not saved automatically
// - clear enable takes effect at once
// - one instruction runs after set enable
// - entry takes four cycles, pushes counter
// - vector jump takes three cycles
// - multi-cycle instruction finishes before entry
// - wake from sleep adds four cycles
// - return takes four cycles, pops counter
// - program counter is fourteen bits
// - core runs undivided, single cycle ALU
// - global enable is status bit seven
// - push lowers stack pointer by two
`timescale 1ns/1ps
module cis_core_interrupt_sequencer
  import cis_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // interrupt sources
  input  wire logic [CIS_NSRC-1:0] reqEvent,
  input  wire logic [CIS_NSRC-1:0] reqLevel,
  input  wire logic [CIS_NSRC-1:0] isLevelType,
  input  wire logic [CIS_NSRC-1:0] irqEnable,
  // software flag clear, one bit clears one flag
  input  wire logic                 flagClrWr,
  input  wire logic [CIS_NSRC-1:0] flagClrData,
  // status register write
  input  wire logic                 statusWr,
  input  wire logic [7:0]           statusWrData,
  // configuration and pipeline
  input  wire cis_cfg_t             cfg,
  input  wire cis_pipe_t            pipe,
  input  wire logic [CIS_PCW-1:0]  curPc,
  // outputs to pipeline
  output logic [CIS_NSRC-1:0]       flagStatus,
  output logic [7:0]                statusReg,
  output logic                      coreHold,
  output logic                      vectorLoad,
  output logic [CIS_PCW-1:0]        vectorAddr,
  output logic [CIS_SPW-1:0]        stackPtr,
  output logic [CIS_PCW-1:0]        retPc,
  output logic                      pushPc,
  output logic                      popPc
);

  ////////////////////////////////////////////////////////////////////////
  // operating notes
  //
  // sequencer states
  //   run:   core executes, requests looked at on boundaries
  //   wake:  extra cycles when the core sleeps at the take
  //   entry: return address pushed, stack pointer lowered
  //   jump:  the jump at the vector, then the vector load
  //   return_from_irq_instr:  return address popped, global enable restored
  //
  // take conditions, all in one cycle
  //   state is run and the pipeline shows a boundary
  //   some enabled source is pending
  //   global enable bit is set
  //   no clear-enable instruction ends in this cycle
  //   no return instruction ends in this cycle
  //   no hold-off after set-enable or return
  //   lock bits do not block the current section
  //
  // priority
  //   source index 0 sits at the lowest vector
  //   lower index always wins, no rotation
  //   the winner is frozen at the take edge, so a
  //   later request cannot change the vector in flight
  //
  // event sources
  //   a high request cycle sets the flag
  //   the flag stays set while masked
  //   the flag clears when its vector is taken
  //   software clears it by writing a one
  //   a new event in the clear cycle keeps it set,
  //   so an event is never lost to a late clear
  //
  // level sources
  //   no flag is kept, the raw level is used
  //   a level gone before enabling causes nothing
  //   the source must drop its level in the handler,
  //   or the core re-enters one instruction after return
  //
  // global enable
  //   cleared by hardware at the take edge
  //   cleared at once by the clear instruction
  //   set by the set instruction or at return end
  //   software may write the whole status byte;
  //   hardware updates of bit seven win over it
  //
  // hold-off
  //   after a return one instruction must run
  //   after a set from disabled one instruction runs
  //   it ends on the next boundary in run state
  //
  // stack pointer
  //   lowered by two at the take edge
  //   raised by two when a return is accepted
  //   no check against the bottom of data memory;
  //   software must set it up before enabling
  //
  // reset vector
  //   vector register is cleared by reset
  //   first cycle after release picks the reset
  //   vector, boot start when the fuse is set
  //   second cycle loads it into the pipeline
  //   core is held for both cycles
  //
  // vector table
  //   table base is app or boot start by select bit
  //   entry n sits at base plus step times n plus one
  //   slot zero of the table belongs to reset
  //
  // timing
  //   entry four cycles, jump three cycles
  //   wake adds four cycles ahead of entry
  //   return four cycles
  //   sleep start-up time is outside this block
  //
  // limitations
  //   status flags other than bit seven are not
  //   touched; handlers save them themselves
  //   lock check uses the pc of the boundary cycle

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // base address of the vector table
  function automatic logic [CIS_PCW-1:0] vecBase(input logic boot);
    vecBase = boot ? CIS_BOOT_BASE : CIS_APP_BASE;
  endfunction

  cis_state_t                state_r;
  cis_state_t                state_nxt;
  logic [2:0]                cnt_r;
  logic [CIS_NSRC-1:0]       flag_r;
  logic [7:0]                status_reg_r;
  logic [CIS_SPW-1:0]        sp_r;
  logic                      holdOff_r;
  logic [$clog2(CIS_NSRC)-1:0] win_r;
  logic [$clog2(CIS_NSRC)-1:0] win;
  logic                      anyReq;
  logic [CIS_NSRC-1:0]       pend;
  logic                      lockBlock;
  logic                      gie;
  logic                      take;
  logic                      pcInBoot;
  logic                      rstVecArm_r;
  logic                      rstVecDone_r;

  assign gie = status_reg_r[CIS_GIE_BIT];

  ////////////////////////////////////////////////////////////////////////
  // request pending and arbitration

  // lock bits block sources while running from the other section
  assign pcInBoot  = curPc >= CIS_BOOT_BASE;
  assign lockBlock = (cfg.appBootLockBit && !pcInBoot && cfg.vectorTableSelect)
                  || (cfg.bootSectionLockBit && pcInBoot
                      && !cfg.vectorTableSelect);

  // flags for event sources, raw level for level sources
  always_comb begin
    for (int i = 0; i < CIS_NSRC; i++) begin
      pend[i] = (isLevelType[i] ? reqLevel[i] : flag_r[i])
                && irqEnable[i];
    end
  end

  // lowest index wins, loop runs high to low
  always_comb begin
    win    = '0;
    anyReq = 1'b0;
    for (int i = CIS_NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        win    = ($clog2(CIS_NSRC))'(i);
        anyReq = 1'b1;
      end
    end
  end

  // cli in the same cycle beats any request; holdOff covers sei and return_from_irq_instr
  assign take = (state_r == CIS_RUN) && pipe.boundary && anyReq && gie
             && !pipe.cliInstr && !holdOff_r && !lockBlock
             && !pipe.retiInstr;

  ////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CIS_RUN: begin
        if (take) begin
          state_nxt = pipe.asleep ? CIS_WAKE : CIS_ENTRY;
        end else if (pipe.retiInstr && pipe.boundary) begin
          state_nxt = CIS_RETURN_FROM_IRQ_INSTR;
        end
      end
      CIS_WAKE:  if (cnt_r == '0) state_nxt = CIS_ENTRY;
      CIS_ENTRY: if (cnt_r == '0) state_nxt = CIS_JUMP;
      CIS_JUMP:  if (cnt_r == '0) state_nxt = CIS_RUN;
      CIS_RETURN_FROM_IRQ_INSTR:  if (cnt_r == '0) state_nxt = CIS_RUN;
      default:   state_nxt = CIS_RUN;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= CIS_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycle counter loaded on every state change
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      unique case (state_nxt)
        CIS_WAKE:  cnt_r <= CIS_WAKE_CNT;
        CIS_ENTRY: cnt_r <= CIS_ENTRY_CNT;
        CIS_JUMP:  cnt_r <= CIS_JMP_CNT;
        CIS_RETURN_FROM_IRQ_INSTR:  cnt_r <= CIS_RETURN_FROM_IRQ_INSTR_CNT;
        default:   cnt_r <= '0;
      endcase
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end

  // winner captured at the take edge, where wake or entry starts
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      win_r <= '0;
    end else if (take) begin
      win_r <= win;
    end
  end

  // one instruction must pass after sei with gie clear or return_from_irq_instr before a take
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      holdOff_r <= 1'b0;
    end else if (state_r == CIS_RETURN_FROM_IRQ_INSTR && cnt_r == '0) begin
      holdOff_r <= 1'b1;
    end else if (pipe.seiInstr && pipe.boundary && !gie) begin
      holdOff_r <= 1'b1;
    end else if (pipe.boundary && state_r == CIS_RUN) begin
      holdOff_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags: set wins over any clear

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      flag_r <= '0;
    end else begin
      for (int i = 0; i < CIS_NSRC; i++) begin
        if (reqEvent[i]) begin
          flag_r[i] <= 1'b1;
        end else if (flagClrWr && flagClrData[i]) begin
          flag_r[i] <= 1'b0;
        end else if (take && win == i[$clog2(CIS_NSRC)-1:0]
                     && !isLevelType[i]) begin
          flag_r[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status register: only bit seven is touched by hardware

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      status_reg_r <= CIS_STATUS_REG_RST;
    end else begin
      if (statusWr) begin
        status_reg_r <= statusWrData;
      end
      if (take) begin
        status_reg_r[CIS_GIE_BIT] <= 1'b0;
      end else if (pipe.cliInstr) begin
        status_reg_r[CIS_GIE_BIT] <= 1'b0;
      end else if (pipe.seiInstr) begin
        status_reg_r[CIS_GIE_BIT] <= 1'b1;
      end else if (state_r == CIS_RETURN_FROM_IRQ_INSTR && cnt_r == '0) begin
        status_reg_r[CIS_GIE_BIT] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stack pointer and program counter transfer

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sp_r <= CIS_SP_RST;
    end else if (take) begin
      sp_r <= sp_r - CIS_SP_CALL;
    end else if (pipe.retiInstr && pipe.boundary && state_r == CIS_RUN) begin
      sp_r <= sp_r + CIS_SP_CALL;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      retPc <= '0;
    end else if (take) begin
      retPc <= curPc;
    end
  end

  // vector of a winner, table relocatable to boot start
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vectorAddr <= CIS_RST_VEC;
    end else if (!rstVecArm_r) begin
      // reset vector settles one cycle before its load
      vectorAddr <= cfg.bootResetVectorFuse ? CIS_BOOT_BASE
                                            : CIS_RST_VEC;
    end else if (state_r == CIS_ENTRY && cnt_r == '0) begin
      vectorAddr <= vecBase(cfg.vectorTableSelect)
        + CIS_PCW'(CIS_VEC_STEP) * (CIS_PCW'(win_r) + 14'h0001);
    end
  end

  // reset vector: pick in first cycle, load in second
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rstVecArm_r  <= 1'b0;
      rstVecDone_r <= 1'b0;
    end else begin
      rstVecArm_r  <= 1'b1;
      rstVecDone_r <= rstVecArm_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign flagStatus = flag_r;
  assign statusReg  = status_reg_r;
  assign stackPtr   = sp_r;
  assign pushPc     = state_r == CIS_ENTRY && cnt_r == CIS_ENTRY_CNT;
  assign popPc      = state_r == CIS_RETURN_FROM_IRQ_INSTR && cnt_r == CIS_RETURN_FROM_IRQ_INSTR_CNT;
  assign coreHold   = state_r != CIS_RUN || !rstVecDone_r;
  // second cycle after reset loads the reset vector; single clock
  assign vectorLoad = (state_r == CIS_JUMP && cnt_r == '0)
                   || (rstVecArm_r && !rstVecDone_r);
endmodule

/* File: cis_pipe_model.sv */
// Purpose: instruction pipeline facing the sequencer
// Assumes: one special instruction queued at a time
// Notes:   only boundaries and program counter, no fetch
`timescale 1ns/1ps
module cis_pipe_model
  import cis_pkg::*;
(
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // from the sequencer
  input  wire logic               coreHold,
  input  wire logic               vectorLoad,
  input  wire logic [CIS_PCW-1:0] vectorAddr,
  // op 1 clear, 2 return, 3 set enable
  input  wire logic [1:0]         opReq,
  input  wire logic [1:0]         lenSel,
  input  wire logic               sleepIn,
  // to the sequencer
  output cis_pipe_t               pipe,
  output logic [CIS_PCW-1:0]      curPc
);
  logic [1:0]         cnt_r;
  logic [1:0]         op_r;
  logic [CIS_PCW-1:0] pc_r;
  logic               bnd;
  // boundary only in the last cycle of an instruction
  assign bnd   = cnt_r == 2'h0 && !coreHold;
  assign curPc = pc_r;
  assign pipe  = '{bnd, bnd && op_r == 2'h3, bnd && op_r == 2'h1,
                   bnd && op_r == 2'h2, sleepIn};
  // next length; length 0 is a one-cycle alu op
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      cnt_r <= 2'h0;
    else if (bnd)
      cnt_r <= lenSel;
    else if (!coreHold && cnt_r != 2'h0)
      cnt_r <= cnt_r - 2'h1;
  end
  // queued op waits for a boundary, else it would split an instruction
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      op_r <= 2'h0;
    else if (opReq != 2'h0)
      op_r <= opReq;
    else if (bnd)
      op_r <= 2'h0;
  end
  // counter follows vectors and boundaries
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst)
      pc_r <= '0;
    else if (vectorLoad)
      pc_r <= vectorAddr;
    else if (bnd)
      pc_r <= pc_r + 1'b1;
  end
endmodule

/* File: cis_pkg.sv */
// Purpose: shared constants and types of the core interrupt sequencer
// Assumes: one core clock, word-addressed program memory
// Notes:   source count and boot start are plain defaults
package cis_pkg;
  localparam int          CIS_NSRC      = 8;
  localparam int          CIS_PCW       = 14;
  localparam int          CIS_SPW       = 16;
  localparam int          CIS_VEC_STEP  = 2;
  localparam logic [13:0] CIS_BOOT_BASE = 14'h3800;
  localparam logic [13:0] CIS_APP_BASE  = 14'h0000;
  localparam logic [13:0] CIS_RST_VEC   = 14'h0000;
  localparam int          CIS_GIE_BIT   = 7;
  localparam logic [7:0]  CIS_STATUS_REG_RST  = 8'h00;
  localparam logic [15:0] CIS_SP_RST    = 16'h0000;
  localparam logic [15:0] CIS_SP_CALL   = 16'h0002;
  // entry and return cycle figures, at 250 MHz the figures are cycles
  localparam int          CIS_ENTRY_CYC = 4;
  localparam int          CIS_WAKE_CYC  = 4;
  localparam int          CIS_RETURN_FROM_IRQ_INSTR_CYC  = 4;
  localparam int          CIS_JMP_CYC   = 3;
  localparam logic [2:0]  CIS_ENTRY_CNT = 3'(CIS_ENTRY_CYC - 1);
  localparam logic [2:0]  CIS_WAKE_CNT  = 3'(CIS_WAKE_CYC - 1);
  localparam logic [2:0]  CIS_RETURN_FROM_IRQ_INSTR_CNT  = 3'(CIS_RETURN_FROM_IRQ_INSTR_CYC - 1);
  localparam logic [2:0]  CIS_JMP_CNT   = 3'(CIS_JMP_CYC - 1);

  typedef enum logic [2:0] {
    CIS_RUN   = 3'h0,
    CIS_WAKE  = 3'h1,
    CIS_ENTRY = 3'h2,
    CIS_JUMP  = 3'h3,
    CIS_RETURN_FROM_IRQ_INSTR  = 3'h4
  } cis_state_t;

  // instruction pipeline status bundle
  typedef struct packed {
    logic boundary;   // last cycle of an instruction
    logic seiInstr;
    logic cliInstr;
    logic retiInstr;
    logic asleep;
  } cis_pipe_t;

  // control bits not held in the status register
  typedef struct packed {
    logic vectorTableSelect;
    logic bootResetVectorFuse;
    logic appBootLockBit;
    logic bootSectionLockBit;
  } cis_cfg_t;
endpackage

/* File: cis_sva_checker_sva.sv */
// Purpose: port checks of the interrupt sequencer
// Assumes: one clock, nrst async active low
// Notes:   entry checks look five cycles back after a wake
`timescale 1ns/1ps
module cis_sva_checker
  import cis_pkg::*;
(
  // clock and reset
  input wire logic                sys_clk,
  input wire logic                nrst,
  // inputs watched
  input wire logic [CIS_NSRC-1:0] reqEvent,
  input wire logic                flagClrWr,
  input wire logic [CIS_NSRC-1:0] flagClrData,
  input wire cis_cfg_t            cfg,
  input wire cis_pipe_t           pipe,
  // outputs watched
  input wire logic [CIS_NSRC-1:0] flagStatus,
  input wire logic [7:0]          statusReg,
  input wire logic                vectorLoad,
  input wire logic [CIS_PCW-1:0]  vectorAddr,
  input wire logic [CIS_SPW-1:0]  stackPtr,
  input wire logic                pushPc,
  input wire logic                popPc
);
  logic [CIS_PCW-1:0] vecOfs;
  // offset from whichever table is selected
  assign vecOfs = vectorAddr -
                  (cfg.vectorTableSelect ? CIS_BOOT_BASE : CIS_APP_BASE);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  //////////////////////////////////////////////////////////////////////////
  // entry keeps the vector quiet, then loads it
  sequence s_quiet;
    !vectorLoad [*6];
  endsequence
  sequence s_load;
    vectorLoad;
  endsequence
  a_entry_drops_gie: assert property (
    pushPc |-> !statusReg[CIS_GIE_BIT]) else $error("gie kept on entry");
  a_push_sp_two: assert property (
    pushPc |-> stackPtr == ($past(pipe.asleep) ? $past(stackPtr, 5)
                            : $past(stackPtr)) - CIS_SP_CALL)
    else $error("stack pointer not lowered by two");
  a_entry_span: assert property (
    pushPc |-> s_quiet ##[1:5] s_load) else $error("vector load mistimed");
  a_take_gated: assert property (
    pushPc |-> ($past(pipe.asleep)
      ? $past(statusReg[CIS_GIE_BIT], 5) && $past(pipe.boundary, 5)
      : $past(statusReg[CIS_GIE_BIT]) && $past(pipe.boundary)))
    else $error("entry without enable or boundary");
  // second edge after reset still shows the reset vector load
  a_vector_place: assert property (
    vectorLoad && $past(nrst, 2) |-> !vecOfs[0] && vecOfs inside {[2:16]})
    else $error("vector outside table");
  a_clear_blocks: assert property (
    pipe.cliInstr |=> !pushPc) else $error("entry after clear enable");
  a_return_gie: assert property (
    popPc |-> ##[0:4] statusReg[CIS_GIE_BIT]) else $error("gie not restored");
  a_clear_by_one: assert property (
    flagClrWr |=> (flagStatus & $past(flagClrData & ~reqEvent)) == '0)
    else $error("flag not cleared by one");
  a_event_latch: assert property (
    reqEvent != '0 |=> pushPc || (flagStatus & $past(reqEvent)) ==
    $past(reqEvent)) else $error("event not latched");
endmodule
bind cis_core_interrupt_sequencer cis_sva_checker chk_u (.sys_clk, .nrst,
  .reqEvent, .flagClrWr, .flagClrData, .cfg, .pipe, .flagStatus,
  .statusReg, .vectorLoad, .vectorAddr, .stackPtr, .pushPc, .popPc);

/* File: tb_core_interrupt_sequencer.sv */
// Purpose: self-checking bench of the interrupt sequencer
// Assumes: pipeline model makes the boundaries
// Notes:   masks come from a fixed-seed shift register
`timescale 1ns/1ps
module tb_core_interrupt_sequencer
  import cis_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reqEvent, reqLevel, isLevelType, irqEnable, flagClrData;
  logic [7:0]  flagStatus, statusWrData, statusReg;
  logic        flagClrWr, statusWr, coreHold, vectorLoad, pushPc, popPc;
  logic        sleepIn;
  logic [1:0]  opReq, lenSel;
  logic [13:0] curPc, vectorAddr, retPc;
  logic [15:0] stackPtr;
  logic [15:0] rnd = 16'h86f8;
  cis_cfg_t    cfg;
  cis_pipe_t   pipe;
  int          n_fail, comparisons, nLoads, spExp, n0;
  int          pend[$];
  always #2 sys_clk = ~sys_clk;
  cis_core_interrupt_sequencer dut_u (.sys_clk, .nrst, .reqEvent, .reqLevel,
    .isLevelType, .irqEnable, .flagClrWr, .flagClrData, .statusWr,
    .statusWrData, .cfg, .pipe, .curPc, .flagStatus, .statusReg, .coreHold,
    .vectorLoad, .vectorAddr, .stackPtr, .retPc, .pushPc, .popPc);
  cis_pipe_model pipe_u (.sys_clk, .nrst, .coreHold, .vectorLoad,
    .vectorAddr, .opReq, .lenSel, .sleepIn, .pipe, .curPc);
  // count vector loads once out of reset
  always @(posedge sys_clk) begin
    if (nrst && vectorLoad)
      nLoads++;
  end
  //////////////////////////////////////////////////////////////////////////
  // sixteen-bit shift register, fixed seed for repeatable runs
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [15:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  // one-cycle write: flg picks flag clear over status
  task automatic wr(input bit flg, input logic [7:0] v);
    @(posedge sys_clk);
    statusWr     <= !flg;
    flagClrWr    <= flg;
    statusWrData <= v;
    flagClrData  <= v;
    @(posedge sys_clk);
    statusWr  <= 1'b0;
    flagClrWr <= 1'b0;
  endtask
  task automatic op(input logic [1:0] c, input logic [7:0] ev);
    @(posedge sys_clk);
    opReq    <= c;
    reqEvent <= ev;
    @(posedge sys_clk);
    opReq    <= 2'h0;
    reqEvent <= 8'h00;
  endtask
  task automatic run_irq(input logic [1:0] k);
    logic [7:0] m;
    logic [7:0] left;
    rnd = lfsr(rnd);
    m   = rnd[7:0];
    wr(1'b0, 8'h00);
    irqEnable <= rnd[15:8];
    cfg.vectorTableSelect <= k[0];
    sleepIn <= k[1];
    lenSel  <= rnd[1:0];
    op(2'h0, m);
    @(negedge sys_clk);
    chk(16'(flagStatus), 16'(m), "latched");
    pend = {};
    for (int i = 0; i < 8; i++) if (m[i] && irqEnable[i]) pend.push_back(i);
    left = pend.size() != 0 ? m & ~(8'h01 << pend[0]) : m;
    n0 = nLoads;
    wr(1'b0, 8'h80);
    repeat (20) @(negedge sys_clk);
    chk(16'(nLoads - n0), 16'(pend.size() != 0), "loads");
    chk(16'(coreHold), 16'h0, "hold free");
    if (pend.size() != 0) begin
      chk(16'(vectorAddr), 16'((k[0] ? CIS_BOOT_BASE : 14'h0) + 2 *
          (pend[0] + 1)), "vector");
      chk(16'(flagStatus), 16'(m & ~(8'h01 << pend[0])), "served");
      chk(stackPtr, 16'(spExp - 2), "push");
    end
    wr(1'b1, 8'h00);
    @(negedge sys_clk);
    chk(16'(flagStatus), 16'(left), "zero");
    wr(1'b1, 8'hff);
    @(negedge sys_clk);
    chk(16'(flagStatus), 16'h0, "clear");
    sleepIn <= 1'b0;
    if (pend.size() != 0) begin
      op(2'h2, 8'h00);
      repeat (12) @(negedge sys_clk);
      chk(stackPtr, 16'(spExp), "pop");
      chk(16'(statusReg), 16'h80, "gie back");
    end
    $display("test irq %0d done", k);
  endtask
  task automatic finish_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {reqEvent, reqLevel, isLevelType, irqEnable, flagClrData} = '0;
    {flagClrWr, statusWr, statusWrData, opReq, lenSel, sleepIn} = '0;
    cfg = '0;
    repeat (5) @(posedge sys_clk);
    chk(16'(vectorAddr), 16'(CIS_RST_VEC), "reset vector");
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    for (int k = 0; k < 16; k++) run_irq(2'(k));
    // request lands with the clear instruction
    wr(1'b0, 8'h80);
    irqEnable <= 8'hff;
    repeat (6) @(posedge sys_clk);
    n0 = nLoads;
    op(2'h1, 8'h04);
    repeat (16) @(negedge sys_clk);
    chk(16'(nLoads - n0), 16'h0, "clear block");
    wr(1'b1, 8'hff);
    $display("test clear done");
    // level request gone before enabling
    isLevelType <= 8'h01;
    reqLevel    <= 8'h01;
    repeat (3) @(posedge sys_clk);
    reqLevel <= 8'h00;
    wr(1'b0, 8'h80);
    repeat (16) @(negedge sys_clk);
    chk(16'(nLoads - n0), 16'h0, "level gone");
    $display("test level done");
    // second reset with the boot reset fuse programmed
    cfg.bootResetVectorFuse <= 1'b1;
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(16'(vectorAddr), 16'(CIS_BOOT_BASE), "boot reset");
    chk(16'(curPc), 16'(CIS_BOOT_BASE), "boot start");
    chk(16'(coreHold), 16'h0, "reset hold");
    $display("test reset done");
    finish_test;
  end
  // tests need under 800 cycles; twenty-five times that means a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    finish_test;
  end
endmodule
